// File: inc/mls_defines.svh
// Command codes, field positions, restore values and timing constants
`ifndef MLS_DEFINES_SVH
`define MLS_DEFINES_SVH
`define MLS_CMD_MARGIN_LOW 8'h26
`define MLS_CMD_SLEW_RATE 8'h27
`define MLS_ML_MSB 9
`define MLS_SLEW_EXP 5'h1D
`define MLS_REL_BIT 7
`define MLS_OP_MARGIN_HI 5
`define MLS_OP_MARGIN_LO 4
`define MLS_OP_SEL_LOW 2'h1
`define MLS_ML_RESTORE0 10'h1F0
`define MLS_ML_RESTORE1 10'h1E8
`define MLS_ML_STORE_THRESH 10'h1EC
`define MLS_ML_TOP_BAND 10'h1F4
`define MLS_ML_BOT_BAND 10'h1C4
`define MLS_ML_TOP_CODE 10'h1F8
`define MLS_ML_BOT_CODE 10'h1C0
`define MLS_ML_HALF_STEP 10'h004
`define MLS_ML_STEP_MASK 10'h3F8
`define MLS_UNITY 11'h200
`define MLS_REL_SHIFT 9
`define MLS_CLK_MHZ 50
`define MLS_LSB_UV 1953
`define MLS_RATE_UV {32'd625, 32'd1260, 32'd2440, 32'd4880, 32'd6510, 32'd9770, 32'd13000, 32'd19530}
`define MLS_BAND_LO {8'h00, 8'h08, 8'h0F, 8'h1E, 8'h2A, 8'h3E, 8'h54, 8'h90}
`endif

// File: inc/mls_pkg.sv
// Types shared by the margin-low and slew-rate register bank
package mls_pkg;
  typedef logic [2:0] mls_band_t;
  typedef enum logic [1:0] {
    MLS_HOLD = 2'b00,
    MLS_UP = 2'b01,
    MLS_DOWN = 2'b10
  } mls_ramp_t;
endpackage

// File: inc/mls_rate_if.sv
// Carrier between the register bank and the slew-rate quantiser
`timescale 1ns/100ps
interface mls_rate_if;
  import mls_pkg::*;
  logic [7:0] mant;
  mls_band_t band;
  logic [7:0] ticks;
  mls_band_t nvm_band;
  logic [7:0] nvm_mant;
  modport bank (output mant, output nvm_band, input band, input ticks, input nvm_mant);
  modport quant (input mant, input nvm_band, output band, output ticks, output nvm_mant);
endinterface

// File: logic/mls_rate_quant.sv
// Slew-rate mantissa quantiser: supported band, ramp tick period, restore value
`timescale 1ns/100ps
`include "mls_defines.svh"
module mls_rate_quant #(
  parameter int CLK_MHZ = `MLS_CLK_MHZ,
  parameter int LSB_UV = `MLS_LSB_UV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bank side
  mls_rate_if.quant rif
);
  import mls_pkg::*;
  localparam int unsigned RATE_UV [8] = '`MLS_RATE_UV;
  localparam logic [7:0] BAND_LO [8] = '`MLS_BAND_LO;

  // Longest period rounds down; slowest rate must fit the tick counter
  if ((LSB_UV * CLK_MHZ) / RATE_UV[0] > 255 || (LSB_UV * CLK_MHZ) / RATE_UV[7] < 1) begin : g_bad
    $error("mls_rate_quant: tick period out of range");
  end

  function automatic mls_band_t band_of(input logic [7:0] m);
    band_of = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m >= BAND_LO[i]) begin
        band_of = mls_band_t'(i);
      end
    end
  endfunction

  mls_band_t band_ff;
  logic [7:0] ticks_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      band_ff <= 3'h0;
      ticks_ff <= 8'(LSB_UV * CLK_MHZ / RATE_UV[0]);
    end else begin
      band_ff <= band_of(rif.mant);
      ticks_ff <= 8'(LSB_UV * CLK_MHZ / RATE_UV[band_of(rif.mant)]);
    end
  end

  assign rif.band = band_ff;
  assign rif.ticks = ticks_ff;
  // Restore loads the lowest code of the stored band
  assign rif.nvm_mant = BAND_LO[rif.nvm_band];

  chk_band_top: assert property (@(posedge clock) disable iff (!rst_b)
    rif.mant >= 8'h90 |=> band_ff == 3'h7 && ticks_ff == 8'(LSB_UV * CLK_MHZ / 19530))
    else $error("top slew band not applied");
  chk_band_low: assert property (@(posedge clock) disable iff (!rst_b)
    rif.mant < 8'h08 |=> band_ff == 3'h0)
    else $error("lowest slew band not applied");
endmodule

// File: logic/mls_regs.sv
// Margin-low setpoint and output slew-rate registers with output target ramp
// Notes on behaviour
// - Margin-low selected in operation: target is margin-low setpoint plus trim.
// - Setpoint is a relative factor when mode bit 7 set, using mode LSB.
// - Entering or leaving margin ramps at the programmed slew rate.
// - Margin-low bits 15:10 read zero; bits 9:0 read/write, restored at reset.
// - Restore loads 496 when default-select clear, 488 when set.
// - Store: default-select is zero at 492 and above, one below.
// - Setpoint quantised in 8-code steps from 504 down to 448.
// - Margin-low write outside valid output range is rejected and flagged.
// - Slew register, command 27h, sets ramp rate of all normal target changes.
// - Turn-on and turn-off ramps do not use the programmed slew rate.
// - Slew bits 15:11 read as fixed exponent minus 3.
// - Slew bits 10:8 read zero; bits 7:0 read/write mantissa, restored.
// - Writes to read-only slew bits are ignored.
// - Any mantissa written is kept and read back unchanged.
// - Applied rate is the supported rate of the mantissa band.
// - Restore loads one representative mantissa per supported rate.
`timescale 1ns/100ps
`include "mls_defines.svh"
module mls_regs #(
  parameter int CLK_MHZ = `MLS_CLK_MHZ,
  parameter int LSB_UV = `MLS_LSB_UV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Word transactions from the bus engine, word already assembled low byte first
  input wire logic [7:0] cmd_code,
  input wire logic wr_word,
  input wire logic [15:0] wr_data,
  input wire logic rd_word,
  output logic [15:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic rd_hit_ff,
  output logic invalid_data_ff,
  // Operating context
  input wire logic [7:0] operation,
  input wire logic [7:0] vout_mode,
  input wire logic [15:0] vout_command,
  input wire logic [15:0] vout_trim,
  input wire logic [15:0] vout_max,
  input wire logic [15:0] vout_min,
  input wire logic on_off_ramp,
  // Non-volatile restore and store
  input wire logic nvm_restore,
  input wire logic margin_low_default_select,
  input wire mls_pkg::mls_band_t nvm_rate_band,
  input wire logic nvm_store,
  output logic store_default_select_ff,
  output mls_pkg::mls_band_t store_rate_band_ff,
  output logic store_valid_ff,
  // Regulation loop
  output logic [15:0] vout_target_ff,
  output mls_pkg::mls_ramp_t ramp_state_ff
);
  import mls_pkg::*;

  logic [9:0] margin_low_setpoint_ff;
  logic [7:0] output_slew_rate_ff;
  logic [7:0] tick_cnt_ff;
  logic [15:0] goal;
  logic [15:0] wr_goal;
  logic margin_low_sel;
  logic wr_ml;
  logic wr_bad;
  mls_ramp_t nxt_ramp;

  mls_rate_if rif ();

  mls_rate_quant #(
    .CLK_MHZ(CLK_MHZ),
    .LSB_UV(LSB_UV)
  ) u_quant (
    .clock(clock),
    .rst_b(rst_b),
    .rif(rif)
  );

  assign rif.mant = output_slew_rate_ff;
  assign rif.nvm_band = nvm_rate_band;

  // Setpoint to relative factor in steps of 8 codes
  function automatic logic [9:0] quant_ml(input logic [9:0] v);
    if (v >= `MLS_ML_TOP_BAND) begin
      quant_ml = `MLS_ML_TOP_CODE;
    end else if (v < `MLS_ML_BOT_BAND) begin
      quant_ml = `MLS_ML_BOT_CODE;
    end else begin
      quant_ml = (v + `MLS_ML_HALF_STEP) & `MLS_ML_STEP_MASK;
    end
  endfunction

  // Target from factor, command and trim; clamped to the word range
  function automatic logic [15:0] target_of(input logic [10:0] f, input logic rel,
                                             input logic [15:0] cmd, input logic [15:0] trim);
    logic [26:0] prod;
    logic [16:0] base;
    logic signed [18:0] sum;
    prod = 27'(cmd) * 27'(f);
    base = rel ? prod[25:`MLS_REL_SHIFT] : {6'h00, f};
    sum = $signed({2'h0, base}) + $signed({{3{trim[15]}}, trim});
    if (sum < 0) begin
      target_of = 16'h0000;
    end else if (sum > $signed(19'h0FFFF)) begin
      target_of = 16'hFFFF;
    end else begin
      target_of = sum[15:0];
    end
  endfunction

  assign margin_low_sel =
    operation[`MLS_OP_MARGIN_HI:`MLS_OP_MARGIN_LO] == `MLS_OP_SEL_LOW;

  always_comb begin
    if (margin_low_sel) begin
      goal = target_of({1'b0, quant_ml(margin_low_setpoint_ff)},
                       vout_mode[`MLS_REL_BIT], vout_command, vout_trim);
    end else begin
      goal = target_of(`MLS_UNITY, 1'b1, vout_command, vout_trim);
    end
  end

  // Candidate target of a margin-low write, checked before it is taken
  assign wr_goal = target_of({1'b0, quant_ml(wr_data[`MLS_ML_MSB:0])},
                             vout_mode[`MLS_REL_BIT], vout_command, vout_trim);
  assign wr_ml = wr_word && cmd_code == `MLS_CMD_MARGIN_LOW;
  // Reserved bits set or out of output range is invalid data
  assign wr_bad = wr_data[15:`MLS_ML_MSB + 1] != 6'h00 || wr_goal > vout_max ||
                  wr_goal < vout_min;

  // Margin-low setpoint: written on the fly, restored from the select bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      margin_low_setpoint_ff <= `MLS_ML_RESTORE0;
    end else if (nvm_restore) begin
      margin_low_setpoint_ff <= margin_low_default_select ?
                                `MLS_ML_RESTORE1 : `MLS_ML_RESTORE0;
    end else if (wr_ml && !wr_bad) begin
      margin_low_setpoint_ff <= wr_data[`MLS_ML_MSB:0];
    end
  end

  // Invalid data pulse feeds the status and alert logic
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      invalid_data_ff <= 1'b0;
    end else begin
      invalid_data_ff <= wr_ml && wr_bad && !nvm_restore;
    end
  end

  // Slew mantissa: every value kept; upper bits of the word are dropped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      output_slew_rate_ff <= 8'h00;
    end else if (nvm_restore) begin
      output_slew_rate_ff <= rif.nvm_mant;
    end else if (wr_word && cmd_code == `MLS_CMD_SLEW_RATE) begin
      output_slew_rate_ff <= wr_data[7:0];
    end
  end

  // Word reads; the read-only fields are constants
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      rd_hit_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_word;
      if (rd_word) begin
        unique case (cmd_code)
          `MLS_CMD_MARGIN_LOW: begin
            rd_data_ff <= {6'h00, margin_low_setpoint_ff};
            rd_hit_ff <= 1'b1;
          end
          `MLS_CMD_SLEW_RATE: begin
            rd_data_ff <= {`MLS_SLEW_EXP, 3'h0, output_slew_rate_ff};
            rd_hit_ff <= 1'b1;
          end
          default: begin
            rd_data_ff <= 16'h0000;
            rd_hit_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // Store: default-select derived from the live setpoint, rate band from the quantiser
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      store_default_select_ff <= 1'b0;
      store_rate_band_ff <= 3'h0;
      store_valid_ff <= 1'b0;
    end else begin
      store_valid_ff <= nvm_store;
      if (nvm_store) begin
        store_default_select_ff <= margin_low_setpoint_ff < `MLS_ML_STORE_THRESH;
        store_rate_band_ff <= rif.band;
      end
    end
  end

  // Ramp direction toward the goal
  always_comb begin
    if (vout_target_ff < goal) begin
      nxt_ramp = MLS_UP;
    end else if (vout_target_ff > goal) begin
      nxt_ramp = MLS_DOWN;
    end else begin
      nxt_ramp = MLS_HOLD;
    end
  end

  // One LSB per tick period of the applied rate; turn-on/off ramps are shaped upstream
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vout_target_ff <= 16'h0000;
      tick_cnt_ff <= 8'h00;
      ramp_state_ff <= MLS_HOLD;
    end else if (on_off_ramp) begin
      vout_target_ff <= goal;
      tick_cnt_ff <= 8'h00;
      ramp_state_ff <= MLS_HOLD;
    end else begin
      ramp_state_ff <= nxt_ramp;
      unique case (nxt_ramp)
        MLS_HOLD: begin
          tick_cnt_ff <= 8'h00;
        end
        MLS_UP, MLS_DOWN: begin
          if (tick_cnt_ff + 8'h01 >= rif.ticks) begin
            tick_cnt_ff <= 8'h00;
            vout_target_ff <= nxt_ramp == MLS_UP ? vout_target_ff + 16'h0001 :
                              vout_target_ff - 16'h0001;
          end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
          end
        end
        default: begin
          tick_cnt_ff <= 8'h00;
        end
      endcase
    end
  end

  chk_ml_readback: assert property (@(posedge clock) disable iff (!rst_b)
    rd_word && cmd_code == `MLS_CMD_MARGIN_LOW && !nvm_restore && !wr_word |=>
    rd_valid_ff && rd_data_ff == {6'h00, $past(margin_low_setpoint_ff)})
    else $error("margin-low readback wrong");
  chk_slew_fixed: assert property (@(posedge clock) disable iff (!rst_b)
    rd_word && cmd_code == `MLS_CMD_SLEW_RATE |=> rd_data_ff[15:8] == 8'hE8)
    else $error("slew exponent or zero bits wrong");
  chk_ml_restore: assert property (@(posedge clock) disable iff (!rst_b)
    nvm_restore |=> margin_low_setpoint_ff ==
    ($past(margin_low_default_select) ? 10'h1E8 : 10'h1F0))
    else $error("margin-low restore value wrong");
  chk_store_select: assert property (@(posedge clock) disable iff (!rst_b)
    nvm_store |=> store_valid_ff && store_default_select_ff ==
    ($past(margin_low_setpoint_ff) < 10'h1EC))
    else $error("default-select store wrong");
  chk_bad_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ml && wr_data[15:10] != 6'h00 && !nvm_restore |=>
    invalid_data_ff && $stable(margin_low_setpoint_ff))
    else $error("invalid margin-low write accepted");
  chk_slew_keep: assert property (@(posedge clock) disable iff (!rst_b)
    wr_word && cmd_code == `MLS_CMD_SLEW_RATE && !nvm_restore |=>
    output_slew_rate_ff == $past(wr_data[7:0]))
    else $error("slew mantissa not kept");
  chk_onoff_jump: assert property (@(posedge clock) disable iff (!rst_b)
    on_off_ramp |=> vout_target_ff == $past(goal))
    else $error("turn-on/off target not passed through");
  chk_ramp_pace: assert property (@(posedge clock) disable iff (!rst_b)
    !on_off_ramp && !$past(on_off_ramp) && vout_target_ff != $past(vout_target_ff) |->
    vout_target_ff + 16'h0001 == $past(vout_target_ff) ||
    vout_target_ff == $past(vout_target_ff) + 16'h0001)
    else $error("target stepped more than one LSB");
  chk_ml_select: assert property (@(posedge clock) disable iff (!rst_b)
    margin_low_sel && vout_mode[7] && vout_trim == 16'h0000 && vout_command == 16'h0200 |->
    goal == {6'h00, quant_ml(margin_low_setpoint_ff)})
    else $error("margin-low goal wrong");
  // Range rejection is judged on the quantised candidate, not the raw code
  chk_range_reject: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ml && !nvm_restore && (wr_goal > vout_max || wr_goal < vout_min) |=>
    invalid_data_ff && $stable(margin_low_setpoint_ff))
    else $error("out-of-range margin-low write accepted");
  chk_ml_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_ml && !wr_bad && !nvm_restore |=>
    !invalid_data_ff && margin_low_setpoint_ff == $past(wr_data[9:0]))
    else $error("valid margin-low write not taken");
  chk_ramp_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !on_off_ramp && vout_target_ff == goal |=> ramp_state_ff == MLS_HOLD)
    else $error("ramp active with target at goal");
  chk_read_miss: assert property (@(posedge clock) disable iff (!rst_b)
    rd_word && cmd_code != `MLS_CMD_MARGIN_LOW && cmd_code != `MLS_CMD_SLEW_RATE |=>
    rd_valid_ff && !rd_hit_ff && rd_data_ff == 16'h0000)
    else $error("unknown command read not empty");
endmodule

// File: tb/mls_host_model.sv
// Host model issuing word reads and writes to the register bank
`timescale 1ns/100ps
module mls_host_model (
  // Clock
  input wire logic clock,
  // Strobes
  output logic [7:0] cmd_code,
  output logic wr_word,
  output logic [15:0] wr_data,
  output logic rd_word,
  // Answers
  input wire logic [15:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic invalid_data_ff
);
  int idle_cycles = 0;
  initial begin
    cmd_code = 8'h00;
    wr_word = 1'b0;
    wr_data = 16'h0000;
    rd_word = 1'b0;
  end
  // Whole word per strobe, low byte first already in the word
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic bad);
    repeat (idle_cycles) @(posedge clock);
    @(posedge clock);
    #1;
    cmd_code = cmd;
    wr_data = d;
    wr_word = 1'b1;
    @(posedge clock);
    #1;
    wr_word = 1'b0;
    // Released data flips so a stale word cannot pass
    wr_data = ~d;
    bad = invalid_data_ff;
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
    repeat (idle_cycles) @(posedge clock);
    @(posedge clock);
    #1;
    cmd_code = cmd;
    rd_word = 1'b1;
    @(posedge clock);
    #1;
    rd_word = 1'b0;
    ok = rd_valid_ff;
    d = rd_data_ff;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the margin-low and slew-rate registers
`timescale 1ns/100ps
module tb_top;
  import mls_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cmd_code, operation = 8'h00, vout_mode = 8'h80;
  logic wr_word, rd_word, rd_valid_ff, rd_hit_ff, invalid_data_ff, bad;
  logic [15:0] wr_data, rd_data_ff, vout_target_ff;
  logic [15:0] vout_command = 16'h0200, vout_trim = 16'h0000;
  logic [15:0] vout_max = 16'hFFFF, vout_min = 16'h0000;
  logic on_off_ramp = 1'b1, nvm_restore = 1'b0, nvm_store = 1'b0;
  logic margin_low_default_select = 1'b0, store_default_select_ff, store_valid_ff;
  mls_band_t nvm_rate_band = 3'h0, store_rate_band_ff;
  mls_ramp_t ramp_state_ff;
  int failures = 0;
  int total_checks = 0;
  int gap;
  logic [7:0] lo [8] = '{8'h00, 8'h08, 8'h0F, 8'h1E, 8'h2A, 8'h3E, 8'h54, 8'h90};
  logic [7:0] mv [15] = '{8'h07, 8'h08, 8'h0E, 8'h0F, 8'h1D, 8'h1E, 8'h29, 8'h2A, 8'h3D,
    8'h3E, 8'h53, 8'h54, 8'h8F, 8'h90, 8'hFF};
  logic [9:0] sp [5] = '{10'h1EB, 10'h1F4, 10'h1C3, 10'h1C4, 10'h1F3};
  logic [9:0] qv [5] = '{10'h1E8, 10'h1F8, 10'h1C0, 10'h1C8, 10'h1F0};
  mls_regs dut_u (.clock, .rst_b, .cmd_code, .wr_word, .wr_data, .rd_word, .rd_data_ff,
    .rd_valid_ff, .rd_hit_ff, .invalid_data_ff, .operation, .vout_mode, .vout_command,
    .vout_trim, .vout_max, .vout_min, .on_off_ramp, .nvm_restore,
    .margin_low_default_select, .nvm_rate_band, .nvm_store, .store_default_select_ff,
    .store_rate_band_ff, .store_valid_ff, .vout_target_ff, .ramp_state_ff);
  mls_host_model host_u (.clock, .cmd_code, .wr_word, .wr_data, .rd_word, .rd_data_ff,
    .rd_valid_ff, .invalid_data_ff);
  always #10 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic hit);
    logic [15:0] d;
    logic ok;
    host_u.read_word(c, d, ok);
    check({15'h0, ok}, 16'h0001);
    check({15'h0, rd_hit_ff}, {15'h0, hit});
    check(d, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic exp_bad);
    host_u.write_word(c, d, bad);
    check({15'h0, bad}, {15'h0, exp_bad});
  endtask
  task automatic pulse(input logic st, input logic sel, input mls_band_t b);
    @(posedge clock);
    #1;
    margin_low_default_select = sel;
    nvm_rate_band = b;
    nvm_restore = ~st;
    nvm_store = st;
    @(posedge clock);
    #1;
    nvm_restore = 1'b0;
    nvm_store = 1'b0;
  endtask
  task automatic store(input logic sel, input mls_band_t b);
    pulse(1'b1, 1'b0, 3'h0);
    check({15'h0, store_valid_ff}, 16'h0001);
    check({15'h0, store_default_select_ff}, {15'h0, sel});
    check({13'h0, store_rate_band_ff}, {13'h0, b});
  endtask
  task automatic wait_tgt(input logic [15:0] exp, input int lim);
    int n;
    // Look just after the edge so the launched value has settled
    for (n = 0; n < lim && vout_target_ff !== exp; n++) begin
      @(posedge clock);
      #1;
    end
    check(vout_target_ff, exp);
  endtask
  // Cycles between two target steps; the first step only synchronises
  task automatic step_gap(output int g);
    logic [15:0] t;
    int n;
    for (int k = 0; k < 2; k++) begin
      t = vout_target_ff;
      for (n = 0; n < 400 && vout_target_ff === t; n++) begin
        @(posedge clock);
        #1;
      end
    end
    g = n;
  endtask
  initial begin
    #1_900_000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clock);
    #1;
    rst_b = 1'b1;
    for (int b = 0; b < 8; b++) begin
      pulse(1'b0, b[0], b[2:0]);
      rd(8'h26, b[0] ? 16'h01E8 : 16'h01F0, 1'b1);
      rd(8'h27, {5'h1D, 3'h0, lo[b]}, 1'b1);
      store(b[0], b[2:0]);
    end
    rd(8'h28, 16'h0000, 1'b0);
    $display("test restore done");
    host_u.idle_cycles = 2;
    for (int i = 0; i < 15; i++) begin
      wr(8'h27, {8'hFF, mv[i]}, 1'b0);
      rd(8'h27, {8'hE8, mv[i]}, 1'b1);
      store(1'b1, mls_band_t'(i / 2 + (i % 2)));
    end
    host_u.idle_cycles = 0;
    $display("test slew done");
    wr(8'h26, 16'h01EC, 1'b0);
    rd(8'h26, 16'h01EC, 1'b1);
    store(1'b0, 3'h7);
    wr(8'h26, 16'h01EB, 1'b0);
    store(1'b1, 3'h7);
    wr(8'h26, 16'h0401, 1'b1);
    rd(8'h26, 16'h01EB, 1'b1);
    $display("test store done");
    operation = 8'h10;
    for (int i = 0; i < 5; i++) begin
      wr(8'h26, {6'h0, sp[i]}, 1'b0);
      wait_tgt({6'h0, qv[i]}, 4);
    end
    vout_trim = 16'h0004;
    vout_command = 16'h0400;
    wr(8'h26, 16'h01C3, 1'b0);
    wait_tgt(16'h0384, 4);
    vout_mode = 8'h00;
    wait_tgt(16'h01C4, 4);
    vout_mode = 8'h80;
    // Candidate target 0394h lies one LSB outside each limit in turn
    vout_min = 16'h0395;
    wr(8'h26, 16'h01C4, 1'b1);
    rd(8'h26, 16'h01C3, 1'b1);
    vout_min = 16'h0000;
    vout_max = 16'h0393;
    wr(8'h26, 16'h01C4, 1'b1);
    rd(8'h26, 16'h01C3, 1'b1);
    vout_max = 16'hFFFF;
    operation = 8'h00;
    wait_tgt(16'h0404, 4);
    $display("test target done");
    vout_trim = 16'h0000;
    vout_command = 16'h0200;
    operation = 8'h10;
    wr(8'h26, 16'h01F0, 1'b0);
    wr(8'h27, 16'h0090, 1'b0);
    wait_tgt(16'h01F0, 4);
    on_off_ramp = 1'b0;
    operation = 8'h00;
    step_gap(gap);
    check(16'(gap), 16'd5);
    check({14'h0, ramp_state_ff}, {14'h0, MLS_UP});
    wait_tgt(16'h0200, 200);
    wr(8'h27, 16'h001E, 1'b0);
    operation = 8'h10;
    step_gap(gap);
    check(16'(gap), 16'd20);
    check({14'h0, ramp_state_ff}, {14'h0, MLS_DOWN});
    wait_tgt(16'h01F0, 400);
    @(posedge clock);
    #1;
    check({14'h0, ramp_state_ff}, {14'h0, MLS_HOLD});
    $display("test ramp done");
    finish_test();
  end
endmodule
